// file: design/pks_sequencer.v
// Function
// [RQ1] Key low 2 s while off starts module
// [RQ2] Key low over 3.1 s, released: shutdown
// [RQ3] Reset low 100 ms, released: module resets
// [RQ4] Host waits 30 ms after supply first
// [RQ5] Grounded key starts module at power-up
// [RQ6] Software shutdown ignored under auto-start
// [RQ7] Supply loss forces immediate power-off
// [RQ8] Host shuts down before removing supply
// [RQ9] Short low pulses cause no change
`timescale 1ns/10ps
`include "pks_defines.vh"

module pks_sequencer #(
    parameter [`PKS_CNT_W-1:0] ON_CYC = `PKS_ON_CYC,
    parameter [`PKS_CNT_W-1:0] OFF_CYC = `PKS_OFF_CYC,
    parameter [`PKS_CNT_W-1:0] RST_CYC = `PKS_RST_CYC,
    parameter [`PKS_CNT_W-1:0] RST_PULSE_CYC = `PKS_RST_PULSE_CYC,
    parameter [`PKS_CNT_W-1:0] SHUT_CYC = `PKS_SHUT_CYC
) (
    // Clock and reset
    input wire i_mclk,
    input wire i_resetn,
    // Control pins from the host
    input wire i_power_key_n,
    input wire i_external_reset_n,
    // Supply monitor and software request
    input wire i_supply_ok,
    input wire i_sw_shutdown,
    // Status
    output reg o_module_on,
    output reg o_startup,
    output reg o_shutdown,
    output reg o_core_reset,
    output reg o_auto_start
);

    localparam [4:0] ST_OFF = 5'h01;
    localparam [4:0] ST_START = 5'h02;
    localparam [4:0] ST_RUN = 5'h04;
    localparam [4:0] ST_SHUT = 5'h08;
    localparam [4:0] ST_RESET = 5'h10;

    reg rst_s1_reg;
    reg rst_s2_reg;
    always @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            rst_s1_reg <= 1'b0;
            rst_s2_reg <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_s2_reg <= rst_s1_reg;
        end
    end
    wire rstn = rst_s2_reg;

    reg [4:0] state_reg;
    reg [4:0] state_next;
    wire [`PKS_CNT_W-1:0] key_cnt;
    wire [`PKS_CNT_W-1:0] ext_cnt;
    reg [`PKS_CNT_W-1:0] seq_cnt_reg;
    reg [`PKS_CNT_W-1:0] seq_cnt_next;
    reg key_armed_reg;
    reg key_armed_next;
    reg off_ready_reg;
    reg off_ready_next;
    reg ext_long_reg;
    reg first_reg;
    reg auto_reg;
    reg auto_next;

    wire key_low = ~i_power_key_n;
    wire ext_low = ~i_external_reset_n;
    wire key_on_met = key_cnt >= (ON_CYC - 32'h1);
    wire key_off_met = key_cnt >= (OFF_CYC - 32'h1);
    wire ext_release = ~ext_low & ext_long_reg;

    // Low-time counters clear on release
    pks_low_timer #(
        .CNT_W(`PKS_CNT_W)
    ) i_key_timer (
        .i_mclk(i_mclk),
        .i_rstn(rstn),
        .i_low(key_low),
        .o_count(key_cnt)
    );

    pks_low_timer #(
        .CNT_W(`PKS_CNT_W)
    ) i_ext_timer (
        .i_mclk(i_mclk),
        .i_rstn(rstn),
        .i_low(ext_low),
        .o_count(ext_cnt)
    );

    // Long reset press seen; fires once on release
    always @(posedge i_mclk or negedge rstn) begin
        if (!rstn) begin
            ext_long_reg <= 1'b0;
        end else begin
            ext_long_reg <= ext_low & (ext_cnt >= (RST_CYC - 32'h1)); // RQ9
        end
    end

    always @* begin
        state_next = state_reg;
        seq_cnt_next = seq_cnt_reg;
        key_armed_next = key_armed_reg;
        off_ready_next = off_ready_reg;
        auto_next = auto_reg;
        case (state_reg)
            ST_OFF: begin
                if (first_reg && key_low) begin
                    auto_next = 1'b1;
                    state_next = ST_START; // RQ5
                    seq_cnt_next = 32'h0;
                end else if (key_low && key_on_met) begin
                    state_next = ST_START; // RQ1
                    seq_cnt_next = 32'h0;
                    key_armed_next = 1'b0;
                end
            end
            ST_START: begin
                seq_cnt_next = seq_cnt_reg + 32'h1;
                if (seq_cnt_reg >= (RST_PULSE_CYC - 32'h1)) begin
                    state_next = ST_RUN;
                    seq_cnt_next = 32'h0;
                end
            end
            ST_RUN: begin
                // Key must go high once before an off press counts
                if (!key_low && !auto_reg)
                    key_armed_next = 1'b1;
                // Long enough off press; acted on at release
                if (key_armed_reg && key_low && key_off_met)
                    off_ready_next = 1'b1; // RQ9
                if (ext_release) begin
                    state_next = ST_RESET; // RQ3
                    seq_cnt_next = 32'h0;
                    off_ready_next = 1'b0;
                end else if (off_ready_reg && !key_low) begin
                    state_next = ST_SHUT; // RQ2
                    seq_cnt_next = 32'h0;
                    off_ready_next = 1'b0;
                end else if (i_sw_shutdown && !auto_reg) begin
                    state_next = ST_SHUT; // RQ6
                    seq_cnt_next = 32'h0;
                    off_ready_next = 1'b0;
                end
            end
            ST_SHUT: begin
                seq_cnt_next = seq_cnt_reg + 32'h1;
                if (seq_cnt_reg >= (SHUT_CYC - 32'h1))
                    state_next = ST_OFF;
            end
            ST_RESET: begin
                seq_cnt_next = seq_cnt_reg + 32'h1;
                if (seq_cnt_reg >= (RST_PULSE_CYC - 32'h1)) begin
                    state_next = ST_RUN;
                    seq_cnt_next = 32'h0;
                end
            end
            default: begin
                state_next = ST_OFF;
            end
        endcase
        if (!i_supply_ok) begin
            state_next = ST_OFF; // RQ7
            seq_cnt_next = 32'h0;
            key_armed_next = 1'b0;
            off_ready_next = 1'b0;
        end
    end

    always @(posedge i_mclk or negedge rstn) begin
        if (!rstn) begin
            state_reg <= ST_OFF;
            seq_cnt_reg <= 32'h0;
            key_armed_reg <= 1'b0;
            off_ready_reg <= 1'b0;
            auto_reg <= 1'b0;
            first_reg <= 1'b1;
            o_module_on <= 1'b0;
            o_startup <= 1'b0;
            o_shutdown <= 1'b0;
            o_core_reset <= 1'b1;
            o_auto_start <= 1'b0;
        end else begin
            state_reg <= state_next;
            seq_cnt_reg <= seq_cnt_next;
            key_armed_reg <= key_armed_next;
            off_ready_reg <= off_ready_next;
            auto_reg <= auto_next;
            first_reg <= 1'b0;
            o_module_on <= (state_next == ST_RUN) || (state_next == ST_RESET) || (state_next == ST_SHUT);
            o_startup <= state_next == ST_START;
            o_shutdown <= state_next == ST_SHUT;
            o_core_reset <= (state_next == ST_OFF) || (state_next == ST_START) || (state_next == ST_RESET);
            o_auto_start <= auto_next;
        end
    end

endmodule

module pks_low_timer #(
    parameter CNT_W = `PKS_CNT_W
) (
    // Clock and reset
    input wire i_mclk,
    input wire i_rstn,
    // Pin held low
    input wire i_low,
    // Cycles held low so far
    output wire [CNT_W-1:0] o_count
);

    reg [CNT_W-1:0] count_reg;

    // Saturates so a stuck-low pin never wraps under a threshold
    always @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            count_reg <= {CNT_W{1'b0}};
        end else if (!i_low) begin
            count_reg <= {CNT_W{1'b0}};
        end else if (count_reg != {CNT_W{1'b1}}) begin
            count_reg <= count_reg + {{(CNT_W-1){1'b0}}, 1'b1};
        end
    end

    assign o_count = count_reg;

endmodule

// file: design/pks_defines.vh
`ifndef PKS_DEFINES_VH
`define PKS_DEFINES_VH

// Clock rate in kHz (20 MHz)
`define PKS_CLK_KHZ 20000
// Minimum hold times in ms
`define PKS_ON_HOLD_MS 2000
`define PKS_OFF_HOLD_MS 3100
`define PKS_RST_HOLD_MS 100
// Cycle counts derived from the times; off is "more than" so one extra cycle
`define PKS_ON_CYC (`PKS_ON_HOLD_MS * `PKS_CLK_KHZ)
`define PKS_OFF_CYC (`PKS_OFF_HOLD_MS * `PKS_CLK_KHZ + 1)
`define PKS_RST_CYC (`PKS_RST_HOLD_MS * `PKS_CLK_KHZ)
// Length of the internal reset pulse and shutdown sequence, cycles
`define PKS_RST_PULSE_CYC 16
`define PKS_SHUT_CYC 64
// Counter width
`define PKS_CNT_W 32

`endif

// file: testbench/pks_host.sv
`timescale 1ns/10ps
module pks_host (
    input wire i_mclk,
    output logic o_key_n = 1'h1,
    output logic o_rst_n = 1'h1
);
    // Holds one pin low for n cycles; pins idle high
    task press(input int n, input bit rst);
        @(negedge i_mclk);
        o_key_n = rst;
        o_rst_n = !rst;
        repeat (n) @(negedge i_mclk);
        o_key_n = 1'h1;
        o_rst_n = 1'h1;
    endtask
endmodule

// file: testbench/pks_sequencer_chk.sv
`timescale 1ns/10ps
module pks_sequencer_chk (
    input wire i_mclk, i_resetn, i_power_key_n, i_external_reset_n, i_supply_ok,
    input wire o_module_on, o_startup, o_shutdown, o_core_reset, o_auto_start
);
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_resetn);
    a_start_key: assert property ($rose(o_startup) |-> !$past(i_power_key_n, 10))
        else $error("start w/o key");
    a_start_len: assert property ($rose(o_startup) |-> o_startup[*4] ##1 (o_module_on && !o_core_reset))
        else $error("start length");
    a_shut_rel: assert property ($rose(o_shutdown) |-> i_power_key_n)
        else $error("early shutdown");
    a_shut_len: assert property ($rose(o_shutdown) |-> o_shutdown[*8] ##1 !o_module_on)
        else $error("shutdown length");
    a_rst_len: assert property (o_module_on && $rose(o_core_reset) |->
        i_external_reset_n ##0 o_core_reset[*4] ##1 !o_core_reset) else $error("reset pulse");
    a_auto_stay: assert property (o_auto_start |-> !o_shutdown)
        else $error("auto shutdown");
    a_supply_off: assert property (!i_supply_ok |=> !o_module_on && !o_shutdown)
        else $error("on w/o supply");
    cover property ($rose(o_startup));
    cover property ($rose(o_shutdown));
    cover property (o_module_on && $rose(o_core_reset));
endmodule
bind pks_sequencer pks_sequencer_chk i_chk (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_power_key_n(i_power_key_n),
    .i_external_reset_n(i_external_reset_n), .i_supply_ok(i_supply_ok), .o_module_on(o_module_on),
    .o_startup(o_startup), .o_shutdown(o_shutdown), .o_core_reset(o_core_reset), .o_auto_start(o_auto_start));

// file: testbench/pks_sequencer_tb.sv
`timescale 1ns/10ps
module pks_sequencer_tb;
    logic clk = 1'h0, resetn = 1'h0, sup = 1'h1, sw = 1'h0, gnd = 1'h0;
    wire k_n, x_n, on, st, sh, cr, au;
    int n_errors = 0, checked = 0;
    initial begin
        forever #25 clk = ~clk;
    end
    pks_host i_host (.i_mclk(clk), .o_key_n(k_n), .o_rst_n(x_n));
    pks_sequencer #(.ON_CYC(20), .OFF_CYC(31), .RST_CYC(10), .RST_PULSE_CYC(4), .SHUT_CYC(8)) i_dut (.i_mclk(clk),
        .i_resetn(resetn), .i_power_key_n(k_n & !gnd),
        .i_external_reset_n(x_n), .i_supply_ok(sup), .i_sw_shutdown(sw), .o_module_on(on), .o_startup(st),
        .o_shutdown(sh), .o_core_reset(cr), .o_auto_start(au));
    task w(input int n);
        repeat (n) @(negedge clk);
    endtask
    task chk(input logic g, e);
        checked++;
        if (g !== e) begin
            n_errors++;
            $display("ERROR %0t %h %h", $time, g, e);
        end
    endtask
    task conclude;
        if (n_errors == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task boot(input logic t);
        resetn = 1'h0;
        gnd = t;
        w(10);
        resetn = 1'h1;
        w(40);
    endtask
    task t_start;
        i_host.press(19, 0);
        w(8);
        chk(on | st, 1'h0);
        i_host.press(21, 0);
        chk(st, 1'h1);
        w(8);
        chk(on & !cr, 1'h1);
    endtask
    task t_reset;
        i_host.press(9, 1);
        w(8);
        chk(cr, 1'h0);
        i_host.press(10, 1);
        w(3);
        chk(cr, 1'h1);
        w(6);
        chk(on & !cr, 1'h1);
    endtask
    task t_off;
        i_host.press(30, 0);
        w(12);
        chk(on, 1'h1);
        i_host.press(32, 0);
        w(4);
        chk(sh, 1'h1);
        w(10);
        chk(on, 1'h0);
    endtask
    task t_sw;
        i_host.press(20, 0);
        w(8);
        chk(on & !cr & !au, 1'h1);
        sw = 1'h1;
        w(2);
        chk(sh, 1'h1);
        sw = 1'h0;
        w(10);
        chk(on, 1'h0);
    endtask
    task t_auto;
        boot(1);
        sw = 1'h1;
        w(20);
        chk(au & on & !sh, 1'h1);
        sup = 1'h0;
        w(1);
        chk(on, 1'h0);
        chk(sh | st, 1'h0);
    endtask
    initial begin
        boot(0);
        t_start;
        t_reset;
        t_off;
        t_sw;
        t_auto;
        conclude;
    end
    initial begin
        #100us;
        n_errors++;
        conclude;
    end
endmodule
